// >>> hw/nco_source.sv
// Decided for this implementation: the Wishbone interface to the registers and the placing of the registers.
module nco_source (
   nco_link_if.source link,
   input wire logic reset,
   input wire logic wbCyc,
   input wire logic wbStb,
   input wire logic wbWe,
   input wire logic [nco_pkg::WB_AW-1:0] wbAdr,
   input wire logic [3:0] wbSel,
   input wire logic [31:0] wbDatW,
   output logic [31:0] wbDatR,
   output logic wbAck
);
   import nco_pkg::*;

   host_state_t stateFf;
   logic [1:0] ctrlFf;
   logic [SEL_W-1:0] freqSelFf;
   logic [FM_W-1:0] freqModFf;
   logic [PM_W-1:0] phaseModFf;
   logic [SEL_W-1:0] hopAddrFf;
   logic [ACC_W-1:0] incFf [CHANNELS];
   logic [ACC_W-1:0] phiIncFf;
   logic writeSigFf;
   logic resetNFf;
   logic clkEnFf;
   logic [SLOT_W-1:0] slotFf;
   logic [CH_W-1:0] chanFf;
   logic [CH_W-1:0] nxt_chan;
   logic [CNT_W-1:0] countFf;
   logic [2*MAG_W-1:0] sampleFf;
   logic [31:0] datRFf;
   logic ackFf;
   logic wbReq;
   logic wbWrite;

   // New request only while ack is low; a write lands on the edge that sees ack
   assign wbReq = wbCyc && wbStb && !ackFf;
   assign wbWrite = wbCyc && wbStb && ackFf && wbWe && (wbSel == 4'hf);

   // ----------------------------------------
   // Wishbone slave registers
   // ----------------------------------------
   // Full-word writes only; partial lanes are acknowledged and ignored
   always_ff @(posedge link.clock) begin
      if (reset) begin
         ctrlFf <= CTRL_RESET_VAL;
         freqSelFf <= '0;
         freqModFf <= '0;
         phaseModFf <= '0;
         hopAddrFf <= '0;
         for (int i = 0; i < CHANNELS; i++) begin
            incFf[i] <= '0;
         end
      end else if (wbWrite) begin
         case (wbAdr)
            REG_CTRL: ctrlFf <= wbDatW[1:0];
            REG_FREQ_SEL: freqSelFf <= wbDatW[SEL_W-1:0];
            REG_FREQ_MOD: freqModFf <= wbDatW[FM_W-1:0];
            REG_PHASE_MOD: phaseModFf <= wbDatW[PM_W-1:0];
            REG_HOP_ADDR: hopAddrFf <= wbDatW[SEL_W-1:0];
            default: begin
               for (int i = 0; i < CHANNELS; i++) begin
                  if (wbAdr == REG_INC_BASE + WB_AW'(4 * i)) begin
                     incFf[i] <= wbDatW;
                  end
               end
            end
         endcase
      end
   end

   // Read data and ack, one cycle after the request is seen
   always_ff @(posedge link.clock) begin
      if (reset) begin
         ackFf <= 1'b0;
         datRFf <= '0;
      end else begin
         ackFf <= wbReq;
         case (wbAdr)
            REG_CTRL: datRFf <= {30'h0, ctrlFf};
            REG_FREQ_SEL: datRFf <= 32'(freqSelFf);
            REG_FREQ_MOD: datRFf <= freqModFf;
            REG_PHASE_MOD: datRFf <= 32'(phaseModFf);
            REG_HOP_ADDR: datRFf <= 32'(hopAddrFf);
            REG_STATUS: datRFf <= {countFf, 14'h0, stateFf};
            REG_SAMPLE: datRFf <= sampleFf;
            default: datRFf <= (wbAdr >= REG_INC_BASE && wbAdr < REG_INC_BASE + WB_AW'(4 * CHANNELS))
                               ? incFf[wbAdr[CH_W+1:2]] : '0;
         endcase
      end
   end

   // ----------------------------------------
   // Link sequencing
   // ----------------------------------------
   always_ff @(posedge link.clock) begin
      if (reset) begin
         stateFf <= ST_RESET;
      end else begin
         case (stateFf)
            ST_RESET: stateFf <= ctrlFf[CTRL_HOLD_BIT] ? ST_RESET : ST_IDLE;
            ST_IDLE: stateFf <= ctrlFf[CTRL_HOLD_BIT] ? ST_RESET : (ctrlFf[CTRL_RUN_BIT] ? ST_RUN : ST_IDLE);
            ST_RUN: stateFf <= ctrlFf[CTRL_HOLD_BIT] ? ST_RESET : (ctrlFf[CTRL_RUN_BIT] ? ST_RUN : ST_IDLE);
            default: stateFf <= ST_RESET;
         endcase
      end
   end

   always_ff @(posedge link.clock) begin
      if (reset) begin
         resetNFf <= 1'b0;
         clkEnFf <= 1'b0;
      end else begin
         resetNFf <= (stateFf != ST_RESET);
         clkEnFf <= (stateFf == ST_RUN);
      end
   end

   // Mirror of the oscillator slot and channel counters
   always_comb begin
      nxt_chan = chanFf;
      if (clkEnFf && slotFf == '0) begin
         nxt_chan = (chanFf == CH_W'(CHANNELS - 1)) ? '0 : chanFf + 1'b1;
      end
   end

   always_ff @(posedge link.clock) begin
      if (reset || !resetNFf) begin
         slotFf <= '0;
         chanFf <= '0;
      end else if (clkEnFf) begin
         slotFf <= (slotFf == SLOT_W'(CPO - 1)) ? '0 : slotFf + 1'b1;
         chanFf <= nxt_chan;
      end
   end

   // Increment for the next slot; a hop write borrows the bus for one cycle
   always_ff @(posedge link.clock) begin
      if (reset) begin
         phiIncFf <= '0;
         writeSigFf <= 1'b0;
      end else begin
         writeSigFf <= wbWrite && (wbAdr == REG_HOP_DATA);
         phiIncFf <= (wbWrite && wbAdr == REG_HOP_DATA) ? wbDatW : incFf[(reset || !resetNFf) ? '0 : nxt_chan];
      end
   end

   // ----------------------------------------
   // Sample capture
   // ----------------------------------------
   // Samples are taken only under valid; other cycles may hold stale data
   always_ff @(posedge link.clock) begin
      if (reset) begin
         countFf <= '0;
         sampleFf <= '0;
      end else if (link.outValid) begin
         countFf <= countFf + 1'b1;
         sampleFf <= {link.sinOut, link.cosOut};
      end
   end

   assign link.resetN = resetNFf;
   assign link.clkEn = clkEnFf;
   assign link.phiInc = phiIncFf;
   assign link.freqMod = freqModFf;
   assign link.phaseMod = phaseModFf;
   assign link.freqSel = freqSelFf;
   assign link.hopAddr = hopAddrFf;
   assign link.writeSig = writeSigFf;
   assign wbDatR = datRFf;
   assign wbAck = ackFf;
endmodule

// >>> hw/nco_pkg.sv
package nco_pkg;

   // ----------------------------------------
   // Widths
   // ----------------------------------------
   localparam int ACC_W = 32;             // Phase accumulator precision A
   localparam int FM_W = 32;              // Modulator resolution F
   localparam int PM_W = 16;              // Modulator precision P
   localparam int MAG_W = 16;             // Magnitude precision M
   localparam int HOP_DEPTH = 16;         // Hopping register depth
   localparam int SEL_W = $clog2(HOP_DEPTH);
   localparam int CHANNELS = 4;           // Interleaved channels
   localparam int CH_W = $clog2(CHANNELS);
   localparam int SLOT_W = 5;
   localparam int LUT_W = 16;             // Phase bits that reach the amplitude stage
   localparam int LFSR_W = 16;
   localparam int DITHER_W = 4;           // Phase LSBs disturbed by dither

   // ----------------------------------------
   // Build options
   // ----------------------------------------
   typedef enum logic [1:0] {
      ARCH_SINGLE_LOGIC = 2'b00,
      ARCH_SINGLE_DED = 2'b01,
      ARCH_TWO_CYCLE = 2'b10,
      ARCH_SERIAL = 2'b11
   } arch_t;

   localparam arch_t ARCH = ARCH_SINGLE_DED;
   localparam bit dual_output_option = 1'b1;
   localparam bit FM_ENABLE = 1'b1;
   localparam bit PM_ENABLE = 1'b1;
   localparam bit HOP_ENABLE = 1'b0;
   localparam bit DITHER_ENABLE = 1'b1;
   localparam int FM_PIPE = 1;
   localparam int PM_PIPE = 1;

   // ----------------------------------------
   // Latency figures
   // ----------------------------------------
   localparam int DITHER_LAT_OFF = 0;
   localparam int DITHER_LAT_ON = 2;
   localparam int BASE_SINGLE_LOGIC = 11;
   localparam int MAX_SINGLE_LOGIC = 17;
   localparam int BASE_DED_SPECIAL = 8;
   localparam int BASE_DED = 10;
   localparam int MAX_DED = 16;
   localparam int BASE_TWO_CYCLE = 15;
   localparam int SERIAL_BASE_ADD = 2;    // Serial base is 2N + 2
   localparam int SPECIAL_LO = 9;
   localparam int SPECIAL_HI = 18;
   localparam int TWO_CYCLE_CPO = 2;

   localparam bit SPECIAL_CASE = (MAG_W >= SPECIAL_LO) && (MAG_W <= SPECIAL_HI) && dual_output_option;

   localparam int BASE_LAT = (ARCH == ARCH_SINGLE_LOGIC) ? BASE_SINGLE_LOGIC :
                             (ARCH == ARCH_SINGLE_DED) ? (SPECIAL_CASE ? BASE_DED_SPECIAL : BASE_DED) :
                             (ARCH == ARCH_TWO_CYCLE) ? BASE_TWO_CYCLE : 2 * MAG_W + SERIAL_BASE_ADD;
   localparam int ADD_LAT = (DITHER_ENABLE ? DITHER_LAT_ON : DITHER_LAT_OFF)
                            + (FM_ENABLE ? FM_PIPE : 0) + (PM_ENABLE ? PM_PIPE : 0);
   localparam int TOTAL_LAT = BASE_LAT + ((ARCH == ARCH_SERIAL) ? ADD_LAT * MAG_W : ADD_LAT);
   localparam int CPO = (ARCH == ARCH_TWO_CYCLE) ? TWO_CYCLE_CPO : (ARCH == ARCH_SERIAL) ? MAG_W : 1;

   // ----------------------------------------
   // Amplitude stage
   // ----------------------------------------
   localparam logic [LUT_W-1:0] QUARTER_TURN = 16'h4000;
   localparam logic [LUT_W-1:0] HALF_SPAN = 16'h8000;
   localparam int PAR_SHIFT = 13;
   localparam logic [MAG_W-1:0] MAG_LIMIT = 16'h7fff;
   localparam logic [LFSR_W-1:0] LFSR_SEED = 16'hace1;
   localparam logic [LFSR_W-1:0] LFSR_TAPS = 16'hb400;

   // ----------------------------------------
   // Controller register map (byte offsets)
   // ----------------------------------------
   localparam int WB_AW = 8;
   localparam logic [WB_AW-1:0] REG_CTRL = 8'h00;
   localparam logic [WB_AW-1:0] REG_FREQ_SEL = 8'h04;
   localparam logic [WB_AW-1:0] REG_FREQ_MOD = 8'h08;
   localparam logic [WB_AW-1:0] REG_PHASE_MOD = 8'h0c;
   localparam logic [WB_AW-1:0] REG_HOP_ADDR = 8'h10;
   localparam logic [WB_AW-1:0] REG_HOP_DATA = 8'h14;
   localparam logic [WB_AW-1:0] REG_STATUS = 8'h18;
   localparam logic [WB_AW-1:0] REG_SAMPLE = 8'h1c;
   localparam logic [WB_AW-1:0] REG_INC_BASE = 8'h20;
   localparam int CTRL_RUN_BIT = 0;
   localparam int CTRL_HOLD_BIT = 1;
   localparam logic [1:0] CTRL_RESET_VAL = 2'h0;
   localparam int CNT_W = 16;

   typedef enum logic [1:0] {
      ST_RESET = 2'b00,
      ST_IDLE = 2'b01,
      ST_RUN = 2'b10
   } host_state_t;

endpackage

// >>> hw/nco_link_if.sv
interface nco_link_if (
   input wire logic clock
);
   import nco_pkg::*;

   logic resetN;
   logic clkEn;
   logic [ACC_W-1:0] phiInc;
   logic [FM_W-1:0] freqMod;
   logic [PM_W-1:0] phaseMod;
   logic [SEL_W-1:0] freqSel;
   logic [SEL_W-1:0] hopAddr;
   logic writeSig;
   logic [MAG_W-1:0] sinOut;
   logic [MAG_W-1:0] cosOut;
   logic outValid;

   modport oscillator (
      input clock, resetN, clkEn, phiInc, freqMod, phaseMod, freqSel, hopAddr, writeSig,
      output sinOut, cosOut, outValid
   );

   modport source (
      input clock, sinOut, cosOut, outValid,
      output resetN, clkEn, phiInc, freqMod, phaseMod, freqSel, hopAddr, writeSig
   );
endinterface

// >>> hw/sine_shaper.sv
// Parabolic sine approximation, one half-wave per sign
module sine_shaper (
   input wire logic [nco_pkg::LUT_W-1:0] phase,
   output logic [nco_pkg::MAG_W-1:0] amplitude
);
   import nco_pkg::*;

   logic [LUT_W-2:0] frac;
   logic [LUT_W-1:0] rest;
   logic [2*LUT_W-1:0] prod;
   logic [2*LUT_W-1:0] scaled;
   logic [MAG_W-1:0] mag;

   // ----------------------------------------
   // u * (1 - u) per half turn
   // ----------------------------------------
   // Cheap and multiplier-only; error near 5 percent, fine for a timing model
   always_comb begin
      frac = phase[LUT_W-2:0];
      rest = HALF_SPAN - {1'b0, frac};
      prod = {{(LUT_W+1){1'b0}}, frac} * {{LUT_W{1'b0}}, rest};
      scaled = prod >> PAR_SHIFT;
      mag = (scaled > {{LUT_W{1'b0}}, MAG_LIMIT}) ? MAG_LIMIT : scaled[MAG_W-1:0];
      amplitude = phase[LUT_W-1] ? (~mag + 1'b1) : mag;
   end
endmodule

// >>> hw/nco_oscillator.sv
// Function
// - Frequency modulation word F bits wide
// - Selector picks stored increment when hopping
// - Phase offset word P bits wide
// - Phase increment input A bits wide
// - Write strobe stores a hopping register
// - Sine M bits, cosine only if dual
// - Valid flag marks sample on outputs
// - Single-cycle builds give one sample per clock
// - Source holds modulation with matching increment
// - Two-cycle build: one sample per two
// - Serial build: one sample per N
// - Sink qualifies samples with valid flag
// - Latency sums base, dither, modulation pipes
// - Dither adds zero or two cycles
// - Logic-cell multiplier base latency eleven
// - Dedicated special case base latency eight
// - Dedicated otherwise base latency ten
// - Channel zero taken first after reset
// - Valid first rises with channel zero
// - Channels interleave, each every M cycles; this build serves each channel every CHANNELS (4) enabled cycles
module nco_oscillator (
   nco_link_if.oscillator link
);
   import nco_pkg::*;

   // ----------------------------------------
   // Pipeline depth
   // ----------------------------------------
   // Phase register and output register account for two of the stages
   localparam int DLY = TOTAL_LAT - 2;

   logic [SLOT_W-1:0] slotFf;
   logic [CH_W-1:0] chanFf;
   logic [ACC_W-1:0] accFf [CHANNELS];
   logic [ACC_W-1:0] hopFf [HOP_DEPTH];
   logic [ACC_W-1:0] phaseFf;
   logic phaseValidFf;
   logic [ACC_W-1:0] dlyPhaseFf [DLY];
   logic dlyValidFf [DLY];
   logic [LFSR_W-1:0] lfsrFf;
   logic [MAG_W-1:0] sinFf;
   logic [MAG_W-1:0] cosFf;
   logic outValidFf;

   logic accept;
   logic [ACC_W-1:0] baseInc;
   logic [ACC_W-1:0] stepInc;
   logic [ACC_W-1:0] nxt_acc;
   logic [ACC_W-1:0] phaseOffset;
   logic [ACC_W-1:0] tailPhase;
   logic tailValid;
   logic [ACC_W-1:0] ditheredPhase;
   logic [LUT_W-1:0] lutPhase;
   logic [MAG_W-1:0] sinWave;
   logic [MAG_W-1:0] cosWave;

   // ----------------------------------------
   // Input slot timing
   // ----------------------------------------
   // One accept slot every CPO enabled cycles; slot 0 is the first enabled edge
   always_ff @(posedge link.clock or negedge link.resetN) begin
      if (!link.resetN) begin
         slotFf <= '0;
      end else if (link.clkEn) begin
         if (slotFf == SLOT_W'(CPO - 1)) begin
            slotFf <= '0;
         end else begin
            slotFf <= slotFf + 1'b1;
         end
      end
   end

   assign accept = link.clkEn && (slotFf == '0);

   // Channel pointer starts at zero so the first accepted word is channel 0
   always_ff @(posedge link.clock or negedge link.resetN) begin
      if (!link.resetN) begin
         chanFf <= '0;
      end else if (accept) begin
         chanFf <= (chanFf == CH_W'(CHANNELS - 1)) ? '0 : chanFf + 1'b1;
      end
   end

   // ----------------------------------------
   // Frequency hopping registers
   // ----------------------------------------
   // Stored on the strobe alone; a write is not held off by the clock enable
   always_ff @(posedge link.clock or negedge link.resetN) begin
      if (!link.resetN) begin
         for (int i = 0; i < HOP_DEPTH; i++) begin
            hopFf[i] <= '0;
         end
      end else if (HOP_ENABLE && link.writeSig) begin
         hopFf[link.hopAddr] <= link.phiInc;
      end
   end

   // ----------------------------------------
   // Increment selection and modulation
   // ----------------------------------------
   always_comb begin
      baseInc = HOP_ENABLE ? hopFf[link.freqSel] : link.phiInc;
      stepInc = FM_ENABLE ? (baseInc + ACC_W'(link.freqMod)) : baseInc;
      nxt_acc = accFf[chanFf] + stepInc;
      phaseOffset = PM_ENABLE ? {link.phaseMod, {(ACC_W - PM_W){1'b0}}} : '0;
   end

   // Per-channel accumulators; only the channel in its slot moves
   always_ff @(posedge link.clock or negedge link.resetN) begin
      if (!link.resetN) begin
         for (int i = 0; i < CHANNELS; i++) begin
            accFf[i] <= '0;
         end
      end else if (accept) begin
         accFf[chanFf] <= nxt_acc;
      end
   end

   // First pipeline stage: modulated phase plus its valid mark
   always_ff @(posedge link.clock or negedge link.resetN) begin
      if (!link.resetN) begin
         phaseFf <= '0;
         phaseValidFf <= 1'b0;
      end else if (link.clkEn) begin
         phaseFf <= nxt_acc + phaseOffset;
         phaseValidFf <= accept;
      end
   end

   // ----------------------------------------
   // Latency delay line
   // ----------------------------------------
   // Whole line stalls with the clock enable, so no sample is dropped
   generate
      for (genvar s = 0; s < DLY; s++) begin : g_stage
         logic [ACC_W-1:0] stagePhase;
         logic stageValid;

         // Head stage takes the phase register; no stage ever indexes below zero
         if (s == 0) begin : g_head
            assign stagePhase = phaseFf;
            assign stageValid = phaseValidFf;
         end else begin : g_body
            assign stagePhase = dlyPhaseFf[s-1];
            assign stageValid = dlyValidFf[s-1];
         end

         always_ff @(posedge link.clock or negedge link.resetN) begin
            if (!link.resetN) begin
               dlyPhaseFf[s] <= '0;
               dlyValidFf[s] <= 1'b0;
            end else if (link.clkEn) begin
               dlyPhaseFf[s] <= stagePhase;
               dlyValidFf[s] <= stageValid;
            end
         end
      end
   endgenerate

   assign tailPhase = dlyPhaseFf[DLY-1];
   assign tailValid = dlyValidFf[DLY-1];

   // ----------------------------------------
   // Phase dither
   // ----------------------------------------
   // Galois LFSR spreads truncation spurs over the low phase bits
   always_ff @(posedge link.clock or negedge link.resetN) begin
      if (!link.resetN) begin
         lfsrFf <= LFSR_SEED;
      end else if (link.clkEn) begin
         lfsrFf <= (lfsrFf >> 1) ^ (lfsrFf[0] ? LFSR_TAPS : '0);
      end
   end

   always_comb begin
      ditheredPhase = tailPhase;
      if (DITHER_ENABLE) begin
         ditheredPhase = tailPhase + ACC_W'(lfsrFf[DITHER_W-1:0]);
      end
      lutPhase = ditheredPhase[ACC_W-1 -: LUT_W];
   end

   // ----------------------------------------
   // Amplitude stage
   // ----------------------------------------
   sine_shaper u_sine (
      .phase (lutPhase),
      .amplitude (sinWave)
   );

   sine_shaper u_cosine (
      .phase (lutPhase + QUARTER_TURN),
      .amplitude (cosWave)
   );

   // ----------------------------------------
   // Output registers
   // ----------------------------------------
   // Samples may move while valid is low; the sink must look at valid
   always_ff @(posedge link.clock or negedge link.resetN) begin
      if (!link.resetN) begin
         sinFf <= '0;
         cosFf <= '0;
         outValidFf <= 1'b0;
      end else if (link.clkEn) begin
         sinFf <= sinWave;
         cosFf <= dual_output_option ? cosWave : '0;
         outValidFf <= tailValid;
      end else begin
         outValidFf <= 1'b0;  // Stalled cycles carry no new sample
      end
   end

   assign link.sinOut = sinFf;
   assign link.cosOut = cosFf;
   assign link.outValid = outValidFf;
endmodule

// >>> verif/nco_link_checker.sv
module nco_link_checker (
   input wire logic clock,
   input wire logic resetN,
   input wire logic clkEn,
   input wire logic writeSig,
   input wire logic [nco_pkg::MAG_W-1:0] sinOut,
   input wire logic [nco_pkg::MAG_W-1:0] cosOut,
   input wire logic outValid
);
   timeunit 1ns;
   timeprecision 1ns;
   import nco_pkg::*;

   // ------------------------
   // Stream timing checks
   // ------------------------
   logic [7:0] runCnt_ff;

   // Enabled edges since reset; saturates so a long run never re-enters the fill window
   always_ff @(posedge clock) begin
      if (!resetN) begin
         runCnt_ff <= 8'h00;
      end else if (clkEn && runCnt_ff != 8'hff) begin
         runCnt_ff <= runCnt_ff + 8'h01;
      end
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (!resetN);

   AST_RESET_CLR: assert property (disable iff (1'b0) !resetN |-> !outValid && sinOut == '0 && cosOut == '0)
      else $error("outputs not cleared in reset");
   AST_ENABLE_IN_RESET: assert property (disable iff (1'b0) !resetN |-> !clkEn)
      else $error("clock enable high in reset");
   AST_NO_EARLY: assert property (runCnt_ff < TOTAL_LAT |-> !outValid)
      else $error("valid before latency");
   AST_FIRST: assert property (clkEn && runCnt_ff == TOTAL_LAT - 1 |=> $rose(outValid))
      else $error("first valid late");
   AST_STREAM: assert property (clkEn && runCnt_ff >= TOTAL_LAT |=> outValid)
      else $error("gap in sample stream");
   AST_STALL: assert property (!clkEn && !$past(clkEn) |-> !outValid)
      else $error("valid during stall");
   AST_HOLD: assert property (!clkEn |=> $stable(sinOut) && $stable(cosOut))
      else $error("samples moved during stall");
   AST_WRITE_PULSE: assert property (writeSig |=> !writeSig)
      else $error("write strobe too long");
endmodule

// >>> verif/tb_top.sv
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   import nco_pkg::*;

   // ------------------------
   // Bench, model and scenarios
   // ------------------------
   logic clock = 1'b0;
   logic reset = 1'b1;
   logic wbCyc = 1'b0;
   logic wbStb = 1'b0;
   logic wbWe = 1'b0;
   logic [WB_AW-1:0] wbAdr = '0;
   logic [3:0] wbSel = 4'h0;
   logic [31:0] wbDatW = 32'h0;
   logic [31:0] wbDatR;
   logic wbAck;
   logic [31:0] rng = 32'h9f402448;
   logic [31:0] rd;
   int err_count = 0;
   int cmp_count = 0;
   logic [MAG_W-1:0] sq[$];
   logic [MAG_W-1:0] cq[$];
   logic [MAG_W-1:0] sinTab[4];
   logic [MAG_W-1:0] cosTab[4];

   nco_link_if link (.clock(clock));
   nco_oscillator nco_oscillator_i (.link(link));
   nco_source nco_source_i (.link(link), .reset(reset), .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe),
      .wbAdr(wbAdr), .wbSel(wbSel), .wbDatW(wbDatW), .wbDatR(wbDatR), .wbAck(wbAck));
   nco_link_checker nco_link_checker_i (.clock(clock), .resetN(link.resetN), .clkEn(link.clkEn),
      .writeSig(link.writeSig), .sinOut(link.sinOut), .cosOut(link.cosOut), .outValid(link.outValid));

   // 20 MHz clock
   initial begin
      forever #25 clock = ~clock;
   end

   // Capture every qualified sample; unqualified values may be junk
   always @(posedge clock) begin
      if (link.outValid === 1'b1) begin
         sq.push_back(link.sinOut);
         cq.push_back(link.cosOut);
      end
   end

   function logic [31:0] xs();
      rng = rng ^ (rng << 13);
      rng = rng ^ (rng >> 17);
      rng = rng ^ (rng << 5);
      return rng;
   endfunction

   // Tolerance for the approximated amplitude; an unknown stays unknown
   function logic [31:0] near(input logic [MAG_W-1:0] s, input logic [MAG_W-1:0] e);
      logic signed [31:0] d;
      d = $signed(s) - $signed(e);
      return (d < 64 && d > -64) ? 32'(e) : 32'(s);
   endfunction

   task print_verdict();
      $display("Compares %0d, mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         err_count++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // Classic single Wishbone cycle; read data lands in rd
   task wb(input logic we, input logic [7:0] adr, input logic [31:0] dat, input logic [3:0] sel);
      int n;
      @(posedge clock);
      wbCyc <= 1'b1;
      wbStb <= 1'b1;
      wbWe <= we;
      wbAdr <= adr;
      wbDatW <= dat;
      wbSel <= sel;
      n = 0;
      do begin
         @(posedge clock);
         n++;
      end while (wbAck !== 1'b1 && n < 50);
      rd = wbDatR;
      wbCyc <= 1'b0;
      wbStb <= 1'b0;
      if (wbAck !== 1'b1) begin
         err_count++;
         print_verdict();
      end
   endtask

   task do_reset();
      reset <= 1'b1;
      repeat (5) @(posedge clock);
      reset <= 1'b0;
   endtask

   // Enabled edges from first accept to first valid sample
   task measure();
      int n, k, exp;
      exp = ((MAG_W >= 9 && MAG_W <= 18 && dual_output_option) ? 8 : 10) + (DITHER_ENABLE ? 2 : 0)
         + (FM_ENABLE ? FM_PIPE : 0) + (PM_ENABLE ? PM_PIPE : 0);
      n = 0;
      for (k = 0; k < 200; k++) begin
         @(posedge clock);
         if (link.outValid === 1'b1) break;
         if (link.clkEn === 1'b1) n++;
      end
      chk("latency", n, exp);
   endtask

   // Quadrant increments per channel; model tracks each channel's phase quadrant
   task run_stream(input int pm);
      logic [31:0] fm, t;
      logic [31:0] inc[4];
      int rot[4], q[4], i, c, k, f;
      t = xs();
      fm = {t[31:30], 30'h0};
      do_reset();
      sq.delete();
      cq.delete();
      for (c = 0; c < 4; c++) begin
         t = xs();
         inc[c] = (c == 0) ? -fm : {t[1:0], 30'h0};
         rot[c] = 32'(inc[c] + fm) >> 30;
         wb(1'b1, REG_INC_BASE + 8'(4 * c), inc[c], 4'hf);
      end
      wb(1'b1, REG_FREQ_MOD, fm, 4'hf);
      wb(1'b1, REG_PHASE_MOD, {16'h0, 2'(pm), 14'h0}, 4'hf);
      fork
         measure();
         wb(1'b1, REG_CTRL, 32'h1, 4'hf);
      join
      for (k = 0; k < 100 && sq.size() < 24; k++) @(posedge clock);
      chk("sample count", 32'(sq.size() >= 24), 32'h1);
      if (sq.size() >= 24) begin
         chk("ch0 sin", near(sq[0], sinTab[pm]), 32'(sinTab[pm]));
         chk("ch0 cos", near(cq[0], cosTab[pm]), 32'(cosTab[pm]));
         q[0] = pm;
         for (c = 1; c < 4; c++) begin
            q[c] = 0;
            f = 0;
            for (k = 0; k < 4; k++) begin
               if (near(sq[c], sinTab[k]) === 32'(sinTab[k]) && near(cq[c], cosTab[k]) === 32'(cosTab[k])) begin
                  q[c] = k;
                  f = 1;
               end
            end
            chk("start quadrant", f, 1);
         end
         for (i = 4; i < 24; i++) begin
            c = i % 4;
            q[c] = (q[c] + rot[c]) % 4;
            chk("sin", near(sq[i], sinTab[q[c]]), 32'(sinTab[q[c]]));
            chk("cos", near(cq[i], cosTab[q[c]]), 32'(cosTab[q[c]]));
         end
      end
      $display("stream test %0d done", pm);
   endtask

   initial begin
      int i, k;
      logic [31:0] t, hopSeen;
      sinTab = '{16'h0000, MAG_LIMIT, 16'h0000, -MAG_LIMIT};
      cosTab = '{MAG_LIMIT, 16'h0000, -MAG_LIMIT, 16'h0000};
      do_reset();
      wb(1'b0, REG_CTRL, 32'h0, 4'hf);
      chk("ctrl reset", rd, 32'(CTRL_RESET_VAL));
      wb(1'b1, REG_CTRL, 32'h1, 4'h1);
      wb(1'b0, REG_CTRL, 32'h0, 4'hf);
      chk("ctrl partial", rd, 32'h0);
      wb(1'b1, 8'h40, 32'hffffffff, 4'hf);
      wb(1'b0, 8'h40, 32'h0, 4'hf);
      chk("unmapped", rd, 32'h0);
      wb(1'b1, REG_STATUS, 32'hffffffff, 4'hf);
      wb(1'b0, REG_STATUS, 32'h0, 4'hf);
      chk("status state", rd[1:0], ST_IDLE);
      wb(1'b1, REG_FREQ_SEL, 32'h5, 4'hf);
      wb(1'b0, REG_FREQ_SEL, 32'h0, 4'hf);
      chk("selector read", rd, 32'h5);
      chk("selector", link.freqSel, 4'h5);
      $display("register test done");
      // Each run starts with a reset; all runs after the first reset in mid-stream
      for (i = 0; i < 4; i++) run_stream(i);
      wb(1'b1, REG_CTRL, 32'h0, 4'hf);
      repeat (3) @(posedge clock);
      wb(1'b0, REG_SAMPLE, 32'h0, 4'hf);
      chk("last sample", rd, {sq[$], cq[$]});
      wb(1'b0, REG_STATUS, 32'h0, 4'hf);
      chk("valid count", rd[31:16], sq.size());
      $display("sample register test done");
      t = xs();
      hopSeen = 32'h0;
      wb(1'b1, REG_HOP_ADDR, 32'h3, 4'hf);
      fork
         wb(1'b1, REG_HOP_DATA, t, 4'hf);
         for (k = 0; k < 10; k++) begin
            @(posedge clock);
            if (link.writeSig === 1'b1) begin
               hopSeen = link.phiInc;
               break;
            end
         end
      join
      chk("hop data", hopSeen, t);
      chk("hop address", link.hopAddr, 4'h3);
      $display("hop strobe test done");
      print_verdict();
   end
endmodule
